// File: logic/fspid_loop.sv
// Feedback measurement, scaling and PID loop with AXI4-Lite registers
// Function
// RULE1: Analog feedback is reading divided by 16
// RULE2: Pulse sensor power low, flag failed halving
// RULE3: Wraparound folds error into -2048..+2048
// RULE4: Count rising edges, sum recent periods
// RULE5: Edge count divided by frequency divider
// RULE6: Time selected-polarity pulses, 0..65535 ticks
// RULE7: Timing tick selectable 1.5 to 48 MHz
// RULE8: Average widths; timeout records maximum width
// RULE9: Frequency is 0x4000000 over width, divided
// RULE10: Frequency feedback 2048 plus/minus, clamped
// RULE11: Scale feedback between minimum and maximum
// RULE12: Inversion swaps output endpoints 0, 4095
// RULE13: Out-of-range feedback raises disconnect error
// RULE14: Error is scaled feedback minus target
// RULE15: Form proportional, integral, derivative terms
// RULE16: Duty target is negated term sum
// RULE17: Coefficient is numerator over power two
// RULE18: All calculations once per loop period
// RULE19: Integral adds error over divider, fractional
// RULE20: Integral magnitude clamped to limit
// RULE21: Integral cleared on stop, force, zone, off
// RULE22: Optionally clear integral on large proportional
// RULE23: Dead zone zeroes duty with hysteresis
// RULE24: Sum analog samples, shift to 0..65472
// RULE25: Previous error register for derivative
`timescale 1ns/1ps
`default_nettype none
`include "fspid_defines.svh"
module fspid_loop #(
  parameter int PERIOD_CYC = `FSPID_PERIOD_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Feedback pins
  input wire logic analog_feedback_pin_valid,
  input wire logic [9:0] analog_feedback_pin_data,
  input wire logic pulse_feedback_pin,
  output logic sensor_power,
  // Loop inputs
  input wire logic [11:0] target,
  input wire logic stop_error,
  input wire logic force_duty,
  // Loop outputs
  output logic period_tick,
  output logic duty_valid,
  output logic signed [15:0] duty_target,
  output logic fb_disconnect
);
  localparam int PW = $clog2(PERIOD_CYC);
  generate
    if (PERIOD_CYC < 10) begin : g_chk
      $error("fspid_loop: PERIOD_CYC must be at least 10");
    end
  endgenerate

  fspid_pkg::fspid_ctrl_s ctrl_r;
  fspid_pkg::fspid_coef_s coef_r [3];
  fspid_pkg::fspid_state_e st_r;
  logic [11:0] smin_r, smax_r, emin_r, emax_r, dzamt_r, fb_r, sfb_r, tgt_r;
  logic [3:0] idexp_r;
  logic [14:0] ilim_r;
  logic [15:0] fdiv_r, tstep_r, tmo_r, rdg_r, arl_r;
  logic disc_r, inzone_r, pwr_r, tick_r, dvalid_r;
  logic signed [15:0] duty_r;
  logic signed [31:0] ifx_r;
  logic signed [13:0] prev_r;

  // Loop period divider
  logic [PW-1:0] per_r;
  wire tick = per_r == PW'(PERIOD_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_r <= '0;
      tick_r <= 1'b0;
    end else begin
      per_r <= tick ? '0 : per_r + PW'(1);
      tick_r <= tick;
    end
  end

  // Register bus
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, aw_h_r, w_h_r;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_r;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_r, rresp_r;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction
  function automatic logic [31:0] rword(input logic [7:0] a);
    rword = hit(a, `FSPID_A_CTRL) ? {18'h0, ctrl_r} :
      hit(a, `FSPID_A_SCALE) ? {4'h0, smax_r, 4'h0, smin_r} :
      hit(a, `FSPID_A_ERRLIM) ? {4'h0, emax_r, 4'h0, emin_r} :
      hit(a, `FSPID_A_PCOEF) ? {11'h0, coef_r[0].exp, 6'h0, coef_r[0].num} :
      hit(a, `FSPID_A_ICOEF) ? {11'h0, coef_r[1].exp, 6'h0, coef_r[1].num} :
      hit(a, `FSPID_A_DCOEF) ? {11'h0, coef_r[2].exp, 6'h0, coef_r[2].num} :
      hit(a, `FSPID_A_INTEG) ? {12'h0, idexp_r, 1'b0, ilim_r} :
      hit(a, `FSPID_A_FREQ) ? {tstep_r, fdiv_r} :
      hit(a, `FSPID_A_ZONE) ? {4'h0, dzamt_r, tmo_r} :
      hit(a, `FSPID_A_STAT) ? {30'h0, inzone_r, disc_r} :
      hit(a, `FSPID_A_FBV) ? {4'h0, sfb_r, 4'h0, fb_r} :
      hit(a, `FSPID_A_DUTY) ? {ifx_r[31:16], duty_r} :
      hit(a, `FSPID_A_RDG) ? {rdg_r, arl_r} : 32'h0;
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    return a[7:2] <= `FSPID_A_RDG >> 2;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
  endfunction
  wire aw_take = s_axi_awvalid & awready_r;
  wire w_take = s_axi_wvalid & wready_r;
  wire ar_take = s_axi_arvalid & arready_r;
  wire do_wr = aw_h_r & w_h_r;
  wire [31:0] nv = merge(rword(awaddr_q), wdata_q, wstrb_q);
  wire [4:0] nexp = (nv[20:16] > `FSPID_EXP_MAX) ? `FSPID_EXP_MAX : nv[20:16];
  wire [15:0] nstep = (nv[31:16] < 16'(`FSPID_TSTEP_MIN)) ? 16'(`FSPID_TSTEP_MIN) :
    (nv[31:16] > 16'(`FSPID_TSTEP_MAX)) ? 16'(`FSPID_TSTEP_MAX) : nv[31:16];
  wire stat_clr = do_wr & hit(awaddr_q, `FSPID_A_STAT) & wstrb_q[0] & wdata_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready_r, wready_r, arready_r} <= 3'h7;
      {aw_h_r, w_h_r, bvalid_r, rvalid_r} <= 4'h0;
      {bresp_r, rresp_r, awaddr_q, wstrb_q} <= '0;
      {wdata_q, rdata_r} <= '0;
    end else begin
      if (aw_take) {aw_h_r, awready_r, awaddr_q} <= {2'b10, s_axi_awaddr};
      if (w_take) {w_h_r, wready_r, wdata_q, wstrb_q} <= {2'b10, s_axi_wdata, s_axi_wstrb};
      if (do_wr) begin
        {aw_h_r, w_h_r, bvalid_r} <= 3'b001;
        bresp_r <= mapped(awaddr_q) ? 2'h0 : 2'h2;
      end
      if (bvalid_r & s_axi_bready) {bvalid_r, awready_r, wready_r} <= 3'b011;
      if (ar_take) begin
        {rvalid_r, arready_r} <= 2'b10;
        rdata_r <= rword(s_axi_araddr);
        rresp_r <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      end
      if (rvalid_r & s_axi_rready) {rvalid_r, arready_r} <= 2'b01;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= '0;
      {smax_r, smin_r, emax_r, emin_r} <= {`FSPID_FULL, 12'h0, `FSPID_FULL, 12'h0};
      {idexp_r, ilim_r, fdiv_r} <= {4'h0, `FSPID_RST_ILIM, `FSPID_RST_FDIV};
      {tstep_r, tmo_r, dzamt_r} <= {`FSPID_RST_TSTEP, `FSPID_RST_TMO, 12'h0};
    end else if (do_wr) begin
      if (hit(awaddr_q, `FSPID_A_CTRL)) ctrl_r <= fspid_pkg::fspid_ctrl_s'(nv[13:0]);
      if (hit(awaddr_q, `FSPID_A_SCALE)) {smax_r, smin_r} <= {nv[27:16], nv[11:0]};
      if (hit(awaddr_q, `FSPID_A_ERRLIM)) {emax_r, emin_r} <= {nv[27:16], nv[11:0]};
      if (hit(awaddr_q, `FSPID_A_INTEG)) {idexp_r, ilim_r} <= {nv[19:16], nv[14:0]};
      if (hit(awaddr_q, `FSPID_A_FREQ)) {tstep_r, fdiv_r} <= {nstep, nv[15:0]}; // [RULE7]
      if (hit(awaddr_q, `FSPID_A_ZONE)) {dzamt_r, tmo_r} <= {nv[27:16], nv[15:0]};
    end
  end
  for (genvar c = 0; c < 3; c++) begin : g_coef
    always_ff @(posedge aclk) begin
      if (!aresetn) coef_r[c] <= '0; // [RULE17]
      else if (do_wr & hit(awaddr_q, `FSPID_A_PCOEF + 8'(4 * c)))
        coef_r[c] <= {nexp, nv[9:0]}; // [RULE17]
    end
  end

  // Analog feedback accumulation and sensor power check
  logic [16:0] acc_r;
  logic [6:0] acn_r;
  wire is_an = ctrl_r.mode == fspid_pkg::M_ANALOG;
  wire is_fq = ctrl_r.mode == fspid_pkg::M_FREQ;
  wire [2:0] ash = (ctrl_r.ashift > `FSPID_ADC_SHIFT) ? `FSPID_ADC_SHIFT : ctrl_r.ashift;
  wire a_take = analog_feedback_pin_valid & pwr_r & (acn_r < (7'h01 << ash));
  wire pin_chk = is_an & ctrl_r.pin_en;
  wire low_bad = ~pwr_r & analog_feedback_pin_valid &
    ({analog_feedback_pin_data, 1'b0} > {1'b0, arl_r[15:6]});
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {acc_r, acn_r, arl_r} <= '0;
      pwr_r <= 1'b1;
    end else begin
      if (tick) begin
        arl_r <= 16'(acc_r << (`FSPID_ADC_SHIFT - ash)); // [RULE24]
        {acc_r, acn_r} <= '0;
      end else if (a_take) begin
        acc_r <= acc_r + 17'(analog_feedback_pin_data); // [RULE24]
        acn_r <= acn_r + 7'h01;
      end
      if (tick & pin_chk) pwr_r <= 1'b0; // [RULE2]
      else if (analog_feedback_pin_valid) pwr_r <= 1'b1; // [RULE2]
    end
  end

  // Pulse counting and pulse timing
  logic pin_d_r, act_d_r;
  logic [15:0] pc_r, tcnt_r;
  logic [23:0] wacc_r;
  logic [15:0] hist_r [`FSPID_HIST];
  logic [15:0] hin [`FSPID_HIST];
  logic [18:0] hsum;
  wire rise = pulse_feedback_pin & ~pin_d_r;
  wire act = ctrl_r.pol ? pulse_feedback_pin : ~pulse_feedback_pin;
  wire pend = act_d_r & ~act;
  wire [24:0] wsum = {1'b0, wacc_r} + 25'(tstep_r);
  wire tmo_hit = tcnt_r >= tmo_r;
  wire push_w = ctrl_r.timing ? (pend | (tick & tmo_hit)) : tick;
  wire [15:0] push_v = ctrl_r.timing ? (pend ? wacc_r[23:8] : `FSPID_WIDTH_MAX) : pc_r; // [RULE8]
  wire [18:0] rd = ctrl_r.timing ? (hsum >> ctrl_r.pshift) : hsum; // [RULE8]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pin_d_r, act_d_r, pc_r, tcnt_r, wacc_r} <= '0;
    end else begin
      pin_d_r <= pulse_feedback_pin;
      act_d_r <= act;
      if (tick) pc_r <= 16'(rise); // [RULE4]
      else if (rise & (pc_r != 16'hffff)) pc_r <= pc_r + 16'h0001; // [RULE4]
      if (pend) wacc_r <= '0;
      else if (act) wacc_r <= wsum[24] ? 24'hffffff : wsum[23:0]; // [RULE6]
      if (pend) tcnt_r <= '0;
      else if (tick & ~tmo_hit) tcnt_r <= tcnt_r + 16'h0001; // [RULE8]
    end
  end
  for (genvar g = 0; g < `FSPID_HIST; g++) begin : g_hist
    if (g == 0) begin : g_in
      assign hin[g] = push_v;
    end else begin : g_sh
      assign hin[g] = hist_r[g-1];
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) hist_r[g] <= '0;
      else if (push_w) hist_r[g] <= hin[g]; // [RULE4]
    end
  end
  always_comb begin
    hsum = '0;
    for (int i = 0; i < `FSPID_HIST; i++)
      if (i < (1 << ctrl_r.pshift)) hsum = hsum + 19'(hist_r[i]); // [RULE4]
  end

  // Shared divider
  logic [31:0] dq_r, dd_r, dr_r;
  logic [4:0] dc_r;
  wire [32:0] dsh = {dr_r, dq_r[31]};
  wire dge = dsh >= {1'b0, dd_r};
  wire [31:0] drn = dge ? 32'(dsh - {1'b0, dd_r}) : dsh[31:0];
  wire [31:0] dqn = {dq_r[30:0], dge};
  wire ddone = dc_r == 5'h0;

  // Feedback, scaling and range check
  wire [31:0] frq = dq_r;
  wire [11:0] fplus = (frq >= 32'h7ff) ? `FSPID_FULL : `FSPID_MID + frq[11:0];
  wire [11:0] fminus = (frq >= 32'h800) ? 12'h0 : `FSPID_MID - frq[11:0];
  wire [11:0] fb_n = is_an ? arl_r[15:4] : // [RULE1]
    is_fq ? ((tgt_r >= `FSPID_MID) ? fplus : fminus) : 12'h0; // [RULE10]
  wire fb_ge = fb_n >= smax_r;
  wire fb_le = fb_n <= smin_r;
  wire [23:0] snum = 24'(12'(fb_n - smin_r)) * 24'(`FSPID_FULL); // [RULE11]
  wire rbad = (is_an | is_fq) & ctrl_r.err_en & ((fb_n < emin_r) | (fb_n > emax_r));
  wire disc_set = (st_r == fspid_pkg::S_FB & rbad) | (low_bad & ctrl_r.err_en);

  // PID terms
  wire signed [13:0] e0 = $signed({2'b00, sfb_r}) - $signed({2'b00, tgt_r}); // [RULE14]
  wire wrp = ctrl_r.wrap & is_an;
  wire signed [13:0] e1 = (wrp & (e0 > `FSPID_WRAP_HALF)) ? e0 - `FSPID_WRAP_FULL : // [RULE3]
    (wrp & (e0 < -`FSPID_WRAP_HALF)) ? e0 + `FSPID_WRAP_FULL : e0;
  wire signed [24:0] pm = e1 * $signed({1'b0, coef_r[0].num});
  wire signed [24:0] pt = pm >>> coef_r[0].exp; // [RULE15]
  wire signed [31:0] iadd = (32'(e1) <<< `FSPID_IFRAC) >>> idexp_r; // [RULE19]
  wire signed [32:0] isum = 33'(ifx_r) + 33'(iadd);
  wire signed [32:0] ilim = $signed({2'b00, ilim_r, 16'h0});
  wire signed [31:0] ifx_c = (isum > ilim) ? 32'(ilim) : // [RULE20]
    (isum < -ilim) ? 32'(-ilim) : isum[31:0];
  wire signed [15:0] integ_n = iclr ? 16'sh0 : ifx_c[31:16]; // [RULE21]
  wire signed [26:0] im = integ_n * $signed({1'b0, coef_r[1].num});
  wire signed [26:0] it = im >>> coef_r[1].exp; // [RULE15]
  wire signed [14:0] de = 15'(e1) - 15'(prev_r);
  wire signed [25:0] dm = de * $signed({1'b0, coef_r[2].num});
  wire signed [25:0] dt = dm >>> coef_r[2].exp; // [RULE15]
  wire signed [28:0] tot = 29'(pt) + 29'(it) + 29'(dt);
  wire signed [28:0] neg = -tot; // [RULE16]
  wire signed [15:0] sat = (neg > 29'sh7fff) ? 16'sh7fff :
    (neg < -29'sh8000) ? -16'sh8000 : neg[15:0];
  wire [13:0] emag = (e1 < 0) ? 14'(-e1) : 14'(e1);
  wire dz_n = inzone_r ? (emag <= {1'b0, dzamt_r, 1'b0}) : (emag < {2'b00, dzamt_r}); // [RULE23]
  wire pbad = ctrl_r.irst & ((pt > `FSPID_PMAX) | (pt < -`FSPID_PMAX)); // [RULE22]
  wire moff = ~is_an & ~is_fq;
  wire iclr = stop_error | force_duty | dz_n | moff | pbad; // [RULE21]

  // Once-per-period sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= fspid_pkg::S_IDLE;
      {dq_r, dd_r, dr_r, dc_r} <= '0;
      {fb_r, sfb_r, tgt_r, rdg_r, duty_r, prev_r} <= '0; // [RULE25]
      {ifx_r, inzone_r, dvalid_r} <= '0; // [RULE21]
    end else begin
      dvalid_r <= 1'b0;
      if (st_r inside {fspid_pkg::S_DIVA, fspid_pkg::S_DIVB, fspid_pkg::S_DIVS}) begin
        {dq_r, dr_r, dc_r} <= {dqn, drn, dc_r - 5'h01};
      end
      unique case (st_r)
        fspid_pkg::S_IDLE: if (tick_r) begin // [RULE18]
          tgt_r <= target;
          rdg_r <= (rd > 19'h0ffff) ? 16'hffff : rd[15:0];
          {dr_r, dc_r} <= {32'h0, 5'h1f};
          dq_r <= ctrl_r.timing ? `FSPID_FREQ_NUM : 32'(rd); // [RULE9]
          dd_r <= ctrl_r.timing ? 32'(rd) : 32'h1; // [RULE9]
          st_r <= is_fq ? fspid_pkg::S_DIVA : fspid_pkg::S_FB;
        end
        fspid_pkg::S_DIVA: if (ddone) begin
          {dr_r, dc_r, dq_r} <= {32'h0, 5'h1f, dqn};
          dd_r <= (fdiv_r == 16'h0) ? 32'h1 : 32'(fdiv_r); // [RULE5]
          st_r <= fspid_pkg::S_DIVB;
        end
        fspid_pkg::S_DIVB: if (ddone) st_r <= fspid_pkg::S_FB;
        fspid_pkg::S_FB: begin
          fb_r <= fb_n;
          if (fb_ge | fb_le) begin
            sfb_r <= (fb_ge ^ ctrl_r.inv) ? `FSPID_FULL : 12'h0; // [RULE11] [RULE12]
            st_r <= fspid_pkg::S_PID;
          end else begin
            {dr_r, dc_r, dq_r} <= {32'h0, 5'h1f, 32'(snum)};
            dd_r <= 32'(12'(smax_r - smin_r));
            st_r <= fspid_pkg::S_DIVS;
          end
        end
        fspid_pkg::S_DIVS: if (ddone) begin
          sfb_r <= ctrl_r.inv ? `FSPID_FULL - dqn[11:0] : dqn[11:0]; // [RULE12]
          st_r <= fspid_pkg::S_PID;
        end
        fspid_pkg::S_PID: begin
          ifx_r <= iclr ? 32'sh0 : ifx_c; // [RULE19] [RULE21]
          prev_r <= e1; // [RULE25]
          inzone_r <= dz_n & ~moff;
          duty_r <= (dz_n | moff) ? 16'sh0 : sat; // [RULE16] [RULE23]
          dvalid_r <= 1'b1;
          st_r <= fspid_pkg::S_IDLE;
        end
        default: st_r <= fspid_pkg::S_IDLE;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) disc_r <= 1'b0;
    else disc_r <= disc_set | (disc_r & ~stat_clr); // [RULE13]
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start;
    st_r == fspid_pkg::S_IDLE && tick_r;
  endsequence
  sequence s_wr_both;
    aw_h_r && w_h_r;
  endsequence
  a_period_once: assert property (tick_r |=> !tick_r [*8]) // [RULE18]
    else $error("loop period ran twice");
  a_duty_after: assert property (s_start |-> ##[1:120] dvalid_r) // [RULE18]
    else $error("no duty update in period");
  a_zone_zero: assert property (st_r == fspid_pkg::S_PID && dz_n |=> duty_r == 0 && ifx_r == 0) // [RULE23]
    else $error("dead zone not applied");
  a_int_clear: assert property (st_r == fspid_pkg::S_PID && (stop_error || force_duty)
    |=> ifx_r == 0) // [RULE21]
    else $error("integral not cleared");
  a_int_limit: assert property (st_r == fspid_pkg::S_PID |=> 33'(ifx_r) <= ilim
    && 33'(ifx_r) >= -ilim) // [RULE20]
    else $error("integral beyond limit");
  a_power_low: assert property ($fell(pwr_r) |-> $past(tick) && $past(pin_chk)) // [RULE2]
    else $error("sensor power dropped outside check");
  a_disc_set: assert property (st_r == fspid_pkg::S_FB && rbad |=> disc_r) // [RULE13]
    else $error("range error not flagged");
  a_scale_top: assert property (st_r == fspid_pkg::S_FB && fb_ge && !ctrl_r.inv
    |=> sfb_r == `FSPID_FULL) // [RULE11]
    else $error("scaled feedback not at top");
  a_scale_inv: assert property (st_r == fspid_pkg::S_FB && fb_ge && ctrl_r.inv
    |=> sfb_r == 12'h0) // [RULE12]
    else $error("inverted scaling wrong");
  a_wrap_range: assert property (wrp |-> e1 >= -`FSPID_WRAP_HALF && e1 <= `FSPID_WRAP_HALF) // [RULE3]
    else $error("wrapped error out of range");
  a_write_resp: assert property (s_wr_both |=> bvalid_r ##1 !aw_h_r)
    else $error("write not answered");

  // Outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign sensor_power = pwr_r;
  assign period_tick = tick_r;
  assign duty_valid = dvalid_r;
  assign duty_target = duty_r;
  assign fb_disconnect = disc_r;
endmodule
`default_nettype wire

// File: logic/fspid_defines.svh
// Register offsets, field positions, reset values and timing of the feedback PID loop
`ifndef FSPID_DEFINES_SVH
`define FSPID_DEFINES_SVH
`define FSPID_CLK_HZ 10000000
`define FSPID_PERIOD_MS 10
`define FSPID_PERIOD_CYC (`FSPID_CLK_HZ / 1000 * `FSPID_PERIOD_MS)
`define FSPID_TCLK_MIN_KHZ 1500
`define FSPID_TCLK_MAX_KHZ 48000
`define FSPID_TSTEP_MIN ((`FSPID_TCLK_MIN_KHZ * 256000 + `FSPID_CLK_HZ - 1) / `FSPID_CLK_HZ)
`define FSPID_TSTEP_MAX (`FSPID_TCLK_MAX_KHZ * 256000 / `FSPID_CLK_HZ)
`define FSPID_A_CTRL 8'h00
`define FSPID_A_SCALE 8'h04
`define FSPID_A_ERRLIM 8'h08
`define FSPID_A_PCOEF 8'h0c
`define FSPID_A_ICOEF 8'h10
`define FSPID_A_DCOEF 8'h14
`define FSPID_A_INTEG 8'h18
`define FSPID_A_FREQ 8'h1c
`define FSPID_A_ZONE 8'h20
`define FSPID_A_STAT 8'h24
`define FSPID_A_FBV 8'h28
`define FSPID_A_DUTY 8'h2c
`define FSPID_A_RDG 8'h30
`define FSPID_HI 16
`define FSPID_EXP_MAX 5'h12
`define FSPID_FULL 12'hfff
`define FSPID_MID 12'h800
`define FSPID_WRAP_HALF 14'sh0800
`define FSPID_WRAP_FULL 14'sh1000
`define FSPID_PMAX 25'sh0000258
`define FSPID_IFRAC 16
`define FSPID_FREQ_NUM 32'h04000000
`define FSPID_WIDTH_MAX 16'hffff
`define FSPID_ADC_SHIFT 3'h6
`define FSPID_RST_ILIM 15'h03e8
`define FSPID_RST_FDIV 16'h0001
`define FSPID_RST_TSTEP 16'h0133
`define FSPID_RST_TMO 16'h000a
`define FSPID_HIST 8
`endif

// File: logic/fspid_pkg.sv
// Types of the feedback PID loop
package fspid_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_DIVA = 6'h02, S_DIVB = 6'h04, S_FB = 6'h08, S_DIVS = 6'h10, S_PID = 6'h20
  } fspid_state_e;
  typedef enum logic [1:0] {M_OFF = 2'h0, M_ANALOG = 2'h1, M_FREQ = 2'h2} fspid_mode_e;
  typedef struct packed {
    logic [1:0] pshift;
    logic [2:0] ashift;
    logic irst;
    logic err_en;
    logic pin_en;
    logic wrap;
    logic inv;
    logic pol;
    logic timing;
    logic [1:0] mode;
  } fspid_ctrl_s;
  typedef struct packed {
    logic [4:0] exp;
    logic [9:0] num;
  } fspid_coef_s;
endpackage

// File: testbench/fspid_sensor.sv
// Sensor model: converter sample stream and pulse source on the feedback pins
`timescale 1ns/1ps
`default_nettype none
module fspid_sensor #(
  parameter int DLY = 20
) (
  // Clock, loop tick and sensor power
  input wire logic aclk,
  input wire logic period_tick,
  input wire logic sensor_power,
  // Settings from the bench
  input wire logic [9:0] level,
  input wire logic [7:0] half,
  // Feedback pins
  output logic analog_feedback_pin_valid,
  output logic [9:0] analog_feedback_pin_data,
  output logic pulse_feedback_pin
);
  int dly = 0;
  int ph = 0;
  initial begin
    analog_feedback_pin_valid = 1'b0;
    analog_feedback_pin_data = 10'h000;
    pulse_feedback_pin = 1'b1;
  end
  // One sample per period; a powered-down sensor reads a quarter
  always @(posedge aclk) begin
    dly <= period_tick ? 1 : ((dly > 0 && dly <= DLY) ? dly + 1 : 0);
    analog_feedback_pin_valid <= (dly == DLY);
    analog_feedback_pin_data <= (dly == DLY) ? (sensor_power ? level : level >> 2) :
      ~analog_feedback_pin_data;
  end
  // Square wave of two half periods; idles high on the pull-up
  always @(posedge aclk) begin
    if (half == 8'h00) begin
      pulse_feedback_pin <= 1'b1;
    end else if (ph >= half - 1) begin
      ph <= 0;
      pulse_feedback_pin <= ~pulse_feedback_pin;
    end else begin
      ph <= ph + 1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the feedback PID loop
`timescale 1ns/1ps
`default_nettype none
`include "fspid_defines.svh"
module tb_top;
  localparam int P = 200;
  logic aclk = 1'b0, aresetn = 1'b0, frc = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, half = 8'h00;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wrd, bv, arr, rv, av, pin, pwr, tick, dv, dis;
  logic [1:0] br, rr;
  logic [9:0] ad, lvl = 10'h100;
  logic [11:0] tgt = 12'h3e8;
  logic signed [15:0] duty;
  int miscompares = 0, check_count = 0;
  always #50 aclk = ~aclk;
  fspid_loop #(.PERIOD_CYC(P)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .analog_feedback_pin_valid(av), .analog_feedback_pin_data(ad),
    .pulse_feedback_pin(pin), .sensor_power(pwr), .target(tgt), .stop_error(1'b0),
    .force_duty(frc), .period_tick(tick), .duty_valid(dv), .duty_target(duty),
    .fb_disconnect(dis));
  fspid_sensor sensor (.aclk(aclk), .period_tick(tick), .sensor_power(pwr), .level(lvl),
    .half(half), .analog_feedback_pin_valid(av), .analog_feedback_pin_data(ad),
    .pulse_feedback_pin(pin));
  task automatic wrap_up;
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo(input bit hit);
    if (hit) begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_duty(input logic signed [15:0] e);
    check_count++;
    if (duty !== e) begin
      miscompares++;
      $display("ERROR duty_target expected %0d seen %0d", e, duty);
    end
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    bit ta, tw;
    int n;
    ta = 0;
    tw = 0;
    n = 0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awv === 1'b1 && awr === 1'b1) ta = 1;
      if (wv === 1'b1 && wrd === 1'b1) tw = 1;
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!(ta && tw && bv === 1'b1) && n < 100);
    bre <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, br});
    tmo(n >= 100);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ta;
    int n;
    ta = 0;
    n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arv === 1'b1 && arr === 1'b1) ta = 1;
      if (ta) arv <= 1'b0;
    end while (!(ta && rv === 1'b1) && n < 100);
    d = rdat;
    r = rr;
    rre <= 1'b0;
    tmo(n >= 100);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk($sformatf("reg_%h", a), e, d);
  endtask
  // Wait for k duty updates
  task automatic waitd(input int k);
    int n;
    n = 0;
    repeat (k) begin
      do begin
        @(posedge aclk);
        n++;
      end while (dv !== 1'b1 && n < 1000 * k);
    end
    tmo(n >= 1000 * k);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`FSPID_A_CTRL, 32'h0);
    rchk(`FSPID_A_SCALE, 32'h0fff0000);
    rchk(`FSPID_A_PCOEF, 32'h0);
    rchk(`FSPID_A_INTEG, 32'h000003e8);
    rchk(`FSPID_A_FREQ, 32'h01330001);
    rd(8'h34, d, r);
    chk("unmapped_rresp", 32'h2, {30'h0, r});
    wr(8'h34, 32'h1, 2'h2);
    wr(`FSPID_A_PCOEF, 32'h3);
    wr(`FSPID_A_CTRL, 32'h1);
    waitd(3);
    chk_duty(-16'sd72);
    rchk(`FSPID_A_FBV, 32'h04000400);
    rd(`FSPID_A_RDG, d, r);
    chk("analog_reading", 32'h4000, {16'h0, d[15:0]});
    wr(`FSPID_A_CTRL, 32'h11);
    waitd(3);
    chk_duty(-16'sd6213);
    rchk(`FSPID_A_FBV, 32'h0bff0400);
    tgt <= 12'd4000;
    lvl <= 10'd16;
    wr(`FSPID_A_CTRL, 32'h21);
    waitd(3);
    chk_duty(-16'sd480);
    tgt <= 12'd1000;
    lvl <= 10'd256;
    wr(`FSPID_A_ICOEF, 32'h1);
    wr(`FSPID_A_INTEG, 32'h5);
    wr(`FSPID_A_CTRL, 32'h1);
    waitd(3);
    rchk(`FSPID_A_DUTY, 32'h0005ffb3);
    frc <= 1'b1;
    waitd(2);
    rchk(`FSPID_A_DUTY, 32'h0000ffb8);
    frc <= 1'b0;
    wr(`FSPID_A_ZONE, 32'h0064000a);
    waitd(3);
    rchk(`FSPID_A_DUTY, 32'h0);
    rchk(`FSPID_A_STAT, 32'h2);
    lvl <= 10'd287;
    waitd(3);
    chk_duty(16'sd0);
    lvl <= 10'd301;
    waitd(3);
    chk_duty(-16'sd617);
    wr(`FSPID_A_ZONE, 32'h0000000a);
    wr(`FSPID_A_ERRLIM, 32'h00640000);
    wr(`FSPID_A_CTRL, 32'h81);
    waitd(2);
    chk("fb_disconnect", 32'h1, {31'h0, dis});
    half <= 8'd10;
    tgt <= 12'd2100;
    wr(`FSPID_A_CTRL, 32'h2);
    waitd(3);
    rchk(`FSPID_A_FBV, 32'h080a080a);
    wr(`FSPID_A_FREQ, 32'h01330002);
    tgt <= 12'd1000;
    waitd(3);
    rchk(`FSPID_A_FBV, 32'h07fb07fb);
    tgt <= 12'd2100;
    wr(`FSPID_A_CTRL, 32'he);
    waitd(3);
    rd(`FSPID_A_RDG, d, r);
    chk("pulse_width", 32'h000b, {16'h0, d[31:16]});
    rchk(`FSPID_A_FBV, 32'h0fff0fff);
    wrap_up();
  end
endmodule
`default_nettype wire
